// ==== include/gcfi_defs.vh ====
// Operation
// - every accepted command is answered with an echo frame, identical for writes
// - finished initialization is reported unasked when auto report is on
// - a new initialization command aborts the current one and restarts it
// - a new position command replaces the target of a running move
// - identifier, bit rate and io mode echo only after the value is applied
// - serial frames are 14 bytes: header, id, 8 byte segment, end
// - header bytes ff fe fd fc mark the start of a frame
// - end byte fb marks the end of a frame
// - id byte carries the gripper identifier, 1 to 255, default 1
// - on can the message id is the gripper id, payload is the segment
// - segment is function, sub function, read/write, reserved, 4 data bytes
// - read/write byte is 00 for read or 01 for write only
// - data is signed 32 bit, least significant byte first
// - data of a read request is ignored
// - decode status, identifier, version, bit rate and drop detection codes
// - function 08 sub 01 reads or writes the init auto report setting
// - function 08 sub 02 write starts init, read returns init done
// - function 05 sub 02/03 reads or writes force, 20 to 100
// - function 06 sub 02 reads or writes position, 0 to 100
// - read replies carry the current parameter value in the data field
// - status read gives 0 idle or moving, 2 reached, 3 caught
// - identifier 0 is accepted as a wildcard address
`ifndef GCFI_DEFS_VH
`define GCFI_DEFS_VH
`define GCFI_HDR0      8'hff
`define GCFI_HDR1      8'hfe
`define GCFI_HDR2      8'hfd
`define GCFI_HDR3      8'hfc
`define GCFI_HDR       32'hfffefdfc
`define GCFI_END       8'hfb
`define GCFI_IDX_ID    4'h4
`define GCFI_IDX_FN    4'h5
`define GCFI_IDX_SUB   4'h6
`define GCFI_IDX_RW    4'h7
`define GCFI_IDX_RES   4'h8
`define GCFI_IDX_END   4'hd
`define GCFI_IDX_ONE   4'h1
`define GCFI_RW_READ   8'h00
`define GCFI_RW_WRITE  8'h01
`define GCFI_ID_WILD   8'h00
`define GCFI_ID_RST    8'h01
`define GCFI_FN_FORCE  8'h05
`define GCFI_FN_POS    8'h06
`define GCFI_FN_INIT   8'h08
`define GCFI_FN_STAT   8'h0f
`define GCFI_FN_IO     8'h10
`define GCFI_FN_ID     8'h12
`define GCFI_FN_VER    8'h13
`define GCFI_FN_BAUD   8'h14
`define GCFI_FN_DROP   8'h15
`define GCFI_SUB1      8'h01
`define GCFI_SUB2      8'h02
`define GCFI_SUB3      8'h03
`define GCFI_SUB_IOEN  8'h09
`define GCFI_AUTO_YES  32'h000000a5
`define GCFI_FORCE_MIN 32'h00000014
`define GCFI_FORCE_MAX 32'h00000064
`define GCFI_POS_MAX   32'h00000064
`define GCFI_ID_MIN    32'h00000001
`define GCFI_ID_MAX    32'h000000ff
`define GCFI_ST_IDLE   2'h0
`define GCFI_ST_REACH  2'h2
`define GCFI_ST_CATCH  2'h3
`define GCFI_FORCE_RST 8'h64
`define GCFI_POS_RST   8'h00
`define GCFI_BAUD_RST  8'h00
`define GCFI_VERSION   32'h00000001
`define GCFI_A_CTRL    8'h00
`define GCFI_A_STAT    8'h04
`define GCFI_A_SETPT   8'h08
`define GCFI_A_CFG     8'h0c
`define GCFI_PIN_INIT  2
`define GCFI_PIN_AT    1
`define GCFI_PIN_CATCH 0
`endif

// ==== src/gcfi_core.v ====
`timescale 1ns/1ps
`default_nettype none
`include "gcfi_defs.vh"
module gcfi_core (
  input  wire        mclk,
  input  wire        resetn,
  input  wire [7:0]  rx_byte,
  input  wire        rx_valid,
  input  wire        can_rx_valid,
  input  wire [10:0] can_rx_id,
  input  wire [63:0] can_rx_data,
  output reg  [7:0]  tx_byte,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg         can_tx_valid,
  output reg  [10:0] can_tx_id,
  output reg  [63:0] can_tx_data,
  input  wire        init_ack_pin,
  input  wire        at_target_pin,
  input  wire        caught_pin,
  output reg         init_start,
  output reg         move_start,
  output reg  [7:0]  target_pos,
  output reg  [7:0]  force_open,
  output reg  [7:0]  force_close,
  output reg  [7:0]  baud_sel,
  output reg         io_mode,
  output reg         drop_en,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest
);

  // byte order swap for the little endian data field
  function [31:0] le32;
    input [31:0] v;
    begin
      le32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
  endfunction

  reg  [2:0]   pin_s1;
  reg  [2:0]   pin_s2;
  reg  [2:0]   pin_s3;
  reg  [3:0]   rx_idx;
  reg  [7:0]   p_id;
  reg  [7:0]   p_fn;
  reg  [7:0]   p_sub;
  reg  [7:0]   p_rw;
  reg  [7:0]   p_res;
  reg  [31:0]  p_data;
  reg          cmd_go;
  reg          cmd_can;
  reg  [7:0]   cmd_id;
  reg  [7:0]   cmd_fn;
  reg  [7:0]   cmd_sub;
  reg  [7:0]   cmd_rw;
  reg  [7:0]   cmd_res;
  reg  [31:0]  cmd_data;
  reg  [7:0]   my_id;
  reg          auto_en;
  reg          init_run;
  reg          init_done;
  reg          init_can;
  reg  [7:0]   init_id;
  reg          moving;
  reg          echo_pend;
  reg          cfg_hold;
  reg          auto_pend;
  reg          e_can;
  reg  [7:0]   e_id;
  reg  [63:0]  e_seg;
  reg  [111:0] tx_sh;
  reg  [3:0]   tx_cnt;
  reg  [7:0]   hdr_exp;
  reg  [31:0]  rd_val;
  reg  [1:0]   st_code;
  reg          snd_go;
  reg          snd_can;
  reg  [7:0]   snd_id;
  reg  [63:0]  snd_seg;
  reg          is_cfg;
  wire         busy;
  wire         init_ack_rise;
  wire         end_rise;
  wire         frame_ok;
  wire         can_ok;
  wire         av_wr;

  assign busy = cmd_go | echo_pend | cfg_hold;
  assign init_ack_rise = pin_s2[`GCFI_PIN_INIT] & ~pin_s3[`GCFI_PIN_INIT];
  assign end_rise = (pin_s2[`GCFI_PIN_AT] & ~pin_s3[`GCFI_PIN_AT]) |
                    (pin_s2[`GCFI_PIN_CATCH] & ~pin_s3[`GCFI_PIN_CATCH]);
  assign av_wr = avs_write & ~avs_waitrequest;
  // wrong end, bad read/write byte or foreign id are dropped
  assign frame_ok = (rx_byte == `GCFI_END) &&
                    (p_rw == `GCFI_RW_READ || p_rw == `GCFI_RW_WRITE) &&
                    (p_id == my_id || p_id == `GCFI_ID_WILD);
  assign can_ok = (can_rx_data[47:40] == `GCFI_RW_READ ||
                   can_rx_data[47:40] == `GCFI_RW_WRITE) &&
                  (can_rx_id == {3'h0, my_id} ||
                   can_rx_id == {3'h0, `GCFI_ID_WILD});
  // two stage sync plus edge stage for plant pins
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end else begin
      pin_s1 <= {init_ack_pin, at_target_pin, caught_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always @* begin
    case (rx_idx)
      4'h0: hdr_exp = `GCFI_HDR0;
      4'h1: hdr_exp = `GCFI_HDR1;
      4'h2: hdr_exp = `GCFI_HDR2;
      default: hdr_exp = `GCFI_HDR3;
    endcase
  end
  // serial frame parser and can intake
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_idx   <= 4'h0;
      p_id     <= 8'h00;
      p_fn     <= 8'h00;
      p_sub    <= 8'h00;
      p_rw     <= 8'h00;
      p_res    <= 8'h00;
      p_data   <= 32'h00000000;
      cmd_go   <= 1'b0;
      cmd_can  <= 1'b0;
      cmd_id   <= 8'h00;
      cmd_fn   <= 8'h00;
      cmd_sub  <= 8'h00;
      cmd_rw   <= 8'h00;
      cmd_res  <= 8'h00;
      cmd_data <= 32'h00000000;
    end else begin
      cmd_go <= 1'b0;
      if (rx_valid) begin
        if (rx_idx < `GCFI_IDX_ID) begin
          if (rx_byte == hdr_exp)
            rx_idx <= rx_idx + `GCFI_IDX_ONE;
          else if (rx_byte == `GCFI_HDR0)
            rx_idx <= `GCFI_IDX_ONE;
          else
            rx_idx <= 4'h0;
        end else begin
          if (rx_idx == `GCFI_IDX_END)
            rx_idx <= 4'h0;
          else
            rx_idx <= rx_idx + `GCFI_IDX_ONE;
          case (rx_idx)
            `GCFI_IDX_ID: p_id <= rx_byte;
            `GCFI_IDX_FN: p_fn <= rx_byte;
            `GCFI_IDX_SUB: p_sub <= rx_byte;
            `GCFI_IDX_RW: p_rw <= rx_byte;
            `GCFI_IDX_RES: p_res <= rx_byte;
            `GCFI_IDX_END: begin
              if (frame_ok && !busy) begin
                cmd_go   <= 1'b1;
                cmd_can  <= 1'b0;
                cmd_id   <= p_id;
                cmd_fn   <= p_fn;
                cmd_sub  <= p_sub;
                cmd_rw   <= p_rw;
                cmd_res  <= p_res;
                cmd_data <= p_data;
              end
            end
            default: p_data <= {rx_byte, p_data[31:8]};
          endcase
        end
      end
      if (can_rx_valid && can_ok && !busy &&
          !(rx_valid && rx_idx == `GCFI_IDX_END && frame_ok)) begin
        cmd_go   <= 1'b1;
        cmd_can  <= 1'b1;
        cmd_id   <= can_rx_id[7:0];
        cmd_fn   <= can_rx_data[63:56];
        cmd_sub  <= can_rx_data[55:48];
        cmd_rw   <= can_rx_data[47:40];
        cmd_res  <= can_rx_data[39:32];
        cmd_data <= le32(can_rx_data[31:0]);
      end
    end
  end

  always @* begin
    if (moving)
      st_code = `GCFI_ST_IDLE;
    else if (pin_s2[`GCFI_PIN_CATCH])
      st_code = `GCFI_ST_CATCH;
    else if (pin_s2[`GCFI_PIN_AT])
      st_code = `GCFI_ST_REACH;
    else
      st_code = `GCFI_ST_IDLE;
  end
  // current value of the addressed parameter
  always @* begin
    rd_val = 32'h00000000;
    case (cmd_fn)
      `GCFI_FN_INIT:
        if (cmd_sub == `GCFI_SUB1)
          rd_val = auto_en ? `GCFI_AUTO_YES : 32'h00000000;
        else
          rd_val = {31'h0, init_done};
      `GCFI_FN_FORCE:
        rd_val = {24'h0, (cmd_sub == `GCFI_SUB2) ?
                  force_close : force_open};
      `GCFI_FN_POS: rd_val = {24'h0, target_pos};
      `GCFI_FN_STAT: rd_val = {30'h0, st_code};
      `GCFI_FN_ID: rd_val = {24'h0, my_id};
      `GCFI_FN_VER: rd_val = `GCFI_VERSION;
      `GCFI_FN_BAUD: rd_val = {24'h0, baud_sel};
      `GCFI_FN_IO: rd_val = {31'h0, io_mode};
      `GCFI_FN_DROP: rd_val = {31'h0, drop_en};
      default: rd_val = 32'h00000000;
    endcase
  end

  always @* begin
    is_cfg = (cmd_rw == `GCFI_RW_WRITE) &&
             (cmd_fn == `GCFI_FN_ID || cmd_fn == `GCFI_FN_BAUD ||
              (cmd_fn == `GCFI_FN_IO && cmd_sub == `GCFI_SUB_IOEN));
    snd_go  = 1'b0;
    snd_can = e_can;
    snd_id  = e_id;
    snd_seg = e_seg;
    if (echo_pend && (e_can || !tx_valid)) begin
      snd_go = 1'b1;
    end else if (auto_pend && (init_can || !tx_valid)) begin
      snd_go  = 1'b1;
      snd_can = init_can;
      snd_id  = init_id;
      snd_seg = {`GCFI_FN_INIT, `GCFI_SUB2, `GCFI_RW_READ, 8'h00,
                 le32({31'h0, 1'b1})};
    end
  end
  // command execution, echo and transmit
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      my_id        <= `GCFI_ID_RST;
      auto_en      <= 1'b0;
      init_run     <= 1'b0;
      init_done    <= 1'b0;
      init_can     <= 1'b0;
      init_id      <= `GCFI_ID_RST;
      moving       <= 1'b0;
      init_start   <= 1'b0;
      move_start   <= 1'b0;
      target_pos   <= `GCFI_POS_RST;
      force_open   <= `GCFI_FORCE_RST;
      force_close  <= `GCFI_FORCE_RST;
      baud_sel     <= `GCFI_BAUD_RST;
      io_mode      <= 1'b0;
      drop_en      <= 1'b0;
      echo_pend    <= 1'b0;
      cfg_hold     <= 1'b0;
      auto_pend    <= 1'b0;
      e_can        <= 1'b0;
      e_id         <= 8'h00;
      e_seg        <= 64'h0;
      tx_sh        <= 112'h0;
      tx_cnt       <= 4'h0;
      tx_byte      <= 8'h00;
      tx_valid     <= 1'b0;
      can_tx_valid <= 1'b0;
      can_tx_id    <= 11'h000;
      can_tx_data  <= 64'h0;
    end else begin
      init_start   <= 1'b0;
      move_start   <= 1'b0;
      can_tx_valid <= 1'b0;
      if (av_wr && avs_address == `GCFI_A_CTRL) begin
        my_id   <= avs_writedata[7:0];
        auto_en <= avs_writedata[8];
      end
      if (end_rise)
        moving <= 1'b0;
      // transmit side clears pending flags first
      if (snd_go) begin
        if (echo_pend && (e_can || !tx_valid))
          echo_pend <= 1'b0;
        else
          auto_pend <= 1'b0;
        if (snd_can) begin
          can_tx_valid <= 1'b1;
          can_tx_id    <= {3'h0, snd_id};
          can_tx_data  <= snd_seg;
        end else begin
          tx_sh    <= {`GCFI_HDR, snd_id, snd_seg, `GCFI_END};
          tx_byte  <= `GCFI_HDR0;
          tx_valid <= 1'b1;
          tx_cnt   <= 4'h0;
        end
      end
      if (tx_valid && tx_ready) begin
        if (tx_cnt == `GCFI_IDX_END) begin
          tx_valid <= 1'b0;
        end else begin
          tx_cnt  <= tx_cnt + `GCFI_IDX_ONE;
          tx_sh   <= {tx_sh[103:0], 8'h00};
          tx_byte <= tx_sh[103:96];
        end
      end
      if (init_run && init_ack_rise) begin
        init_run  <= 1'b0;
        init_done <= 1'b1;
        if (auto_en)
          auto_pend <= 1'b1;
      end
      if (cfg_hold) begin
        cfg_hold  <= 1'b0;
        echo_pend <= 1'b1;
      end
      if (cmd_go) begin
        e_can <= cmd_can;
        e_id  <= cmd_id;
        e_seg <= {cmd_fn, cmd_sub, cmd_rw, cmd_res,
                  le32((cmd_rw == `GCFI_RW_READ) ? rd_val : cmd_data)};
        if (is_cfg)
          cfg_hold <= 1'b1;
        else
          echo_pend <= 1'b1;
        if (cmd_rw == `GCFI_RW_WRITE) begin
          case (cmd_fn)
            `GCFI_FN_INIT:
              if (cmd_sub == `GCFI_SUB1) begin
                auto_en <= (cmd_data != 32'h00000000);
              end else if (cmd_sub == `GCFI_SUB2) begin
                init_run   <= 1'b1;
                init_done  <= 1'b0;
                init_start <= 1'b1;
                init_can   <= cmd_can;
                init_id    <= cmd_id;
              end
            `GCFI_FN_FORCE:
              if (cmd_data >= `GCFI_FORCE_MIN &&
                  cmd_data <= `GCFI_FORCE_MAX) begin
                if (cmd_sub == `GCFI_SUB2)
                  force_close <= cmd_data[7:0];
                else if (cmd_sub == `GCFI_SUB3)
                  force_open <= cmd_data[7:0];
              end
            `GCFI_FN_POS:
              if (cmd_sub == `GCFI_SUB2 &&
                  cmd_data <= `GCFI_POS_MAX) begin
                target_pos <= cmd_data[7:0];
                move_start <= 1'b1;
                moving     <= 1'b1;
              end
            `GCFI_FN_ID:
              if (cmd_data >= `GCFI_ID_MIN &&
                  cmd_data <= `GCFI_ID_MAX)
                my_id <= cmd_data[7:0];
            `GCFI_FN_BAUD: baud_sel <= cmd_data[7:0];
            `GCFI_FN_IO:
              if (cmd_sub == `GCFI_SUB_IOEN)
                io_mode <= cmd_data[0];
            `GCFI_FN_DROP: drop_en <= cmd_data[0];
            default: drop_en <= drop_en;
          endcase
        end
      end
    end
  end
  // avalon slave, answer one cycle after the request
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read || avs_write) begin
        avs_waitrequest <= 1'b0;
        case (avs_address)
          `GCFI_A_CTRL: avs_readdata <= {23'h0, auto_en, my_id};
          `GCFI_A_STAT: avs_readdata <= {27'h0, moving, init_run,
                                         init_done, st_code};
          `GCFI_A_SETPT: avs_readdata <= {8'h00, force_open,
                                          force_close, target_pos};
          `GCFI_A_CFG: avs_readdata <= {22'h0, drop_en, io_mode,
                                        baud_sel};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // gcfi_core
`default_nettype wire

// ==== dv/gcfi_core_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gcfi_defs.vh"
module gcfi_chk (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        can_tx_valid,
  input wire logic [63:0] can_tx_data,
  input wire logic        init_start,
  input wire logic        move_start,
  input wire logic [7:0]  target_pos,
  input wire logic [7:0]  force_open,
  input wire logic [7:0]  force_close
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  ans_next_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("access not answered");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("reply byte not held");
  frame_start_a: assert property ($rose(tx_valid) |->
    tx_byte == `GCFI_HDR0) else $error("reply not opened by header");
  can_rw_a: assert property (can_tx_valid |->
    can_tx_data[47:40] <= `GCFI_RW_WRITE) else $error("bad rw in reply");
  close_range_a: assert property (force_close >= 8'h14 &&
    force_close <= 8'h64) else $error("closing force out of range");
  open_range_a: assert property (force_open >= 8'h14 &&
    force_open <= 8'h64) else $error("opening force out of range");
  pos_range_a: assert property (target_pos <= 8'h64)
    else $error("target out of range");
  move_tgt_a: assert property ($changed(target_pos) |->
    move_start) else $error("silent move");
  init_pulse_a: assert property (init_start |=> !init_start)
    else $error("init start not a pulse");
  echo_c: cover property ($rose(tx_valid));
  can_c: cover property (can_tx_valid);
  init_c: cover property (init_start);
  move_c: cover property (move_start);
endmodule // gcfi_chk
bind gcfi_core gcfi_chk gcfi_chk_i (.mclk(mclk), .resetn(resetn),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .can_tx_valid(can_tx_valid),
  .can_tx_data(can_tx_data), .init_start(init_start),
  .move_start(move_start), .target_pos(target_pos),
  .force_open(force_open), .force_close(force_close));
`default_nettype wire

// ==== dv/gcfi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module gcfi_host (
  input wire logic       mclk,
  input wire logic       slow,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_valid,
  output logic [7:0]     rx_byte,
  output logic           rx_valid,
  output logic           tx_ready
);
  logic [7:0] rxq[$];
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // collect reply bytes, stall every other cycle when slow
  always @(posedge mclk) begin
    if (tx_valid && tx_ready)
      rxq.push_back(tx_byte);
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
  task send(input logic [7:0] id, input logic [63:0] seg,
            input logic [7:0] h0, input logic [7:0] e);
    logic [7:0] b [0:13];
    b[0] = h0;
    b[1] = 8'hfe;
    b[2] = 8'hfd;
    b[3] = 8'hfc;
    b[4] = id;
    for (int i = 0; i < 8; i++)
      b[5+i] = seg[63-8*i -: 8];
    b[13] = e;
    for (int i = 0; i < 14; i++) begin
      @(posedge mclk);
      rx_byte <= b[i];
      rx_valid <= 1'b1;
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_byte <= ~b[13];
  endtask
endmodule // gcfi_host
`default_nettype wire

// ==== dv/test_gripper_command_frame_interpreter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gcfi_defs.vh"
module test_gripper_command_frame_interpreter;
  logic        mclk, resetn, rx_valid, can_rx_valid, tx_valid, tx_ready;
  logic        can_tx_valid, init_ack_pin, at_target_pin, caught_pin;
  logic        init_start, move_start, io_mode, drop_en, avs_read, avs_write;
  logic        avs_waitrequest, slow;
  logic [7:0]  rx_byte, tx_byte, target_pos, force_open, force_close;
  logic [7:0]  baud_sel, avs_address;
  logic [10:0] can_rx_id, can_tx_id;
  logic [63:0] can_rx_data, can_tx_data;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [8:0]  snap;
  int          fails, compares, lat, inits, moves;
  gcfi_core gcfi_core_i (.mclk(mclk), .resetn(resetn), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .can_rx_valid(can_rx_valid),
    .can_rx_id(can_rx_id), .can_rx_data(can_rx_data), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .can_tx_valid(can_tx_valid),
    .can_tx_id(can_tx_id), .can_tx_data(can_tx_data),
    .init_ack_pin(init_ack_pin), .at_target_pin(at_target_pin),
    .caught_pin(caught_pin), .init_start(init_start),
    .move_start(move_start), .target_pos(target_pos),
    .force_open(force_open), .force_close(force_close),
    .baud_sel(baud_sel), .io_mode(io_mode), .drop_en(drop_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  gcfi_host gcfi_host_i (.mclk(mclk), .slow(slow), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_ready(tx_ready));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (init_start === 1'b1) inits++;
    if (move_start === 1'b1) moves++;
  end
  task conclude;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  function logic [63:0] seg(input logic [7:0] fn, input logic [7:0] sub,
                            input logic [7:0] rw, input logic [31:0] d);
    return {fn, sub, rw, 8'h00, d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task expect_frame(input logic [7:0] id, input logic [63:0] es,
                    input logic ok);
    logic [7:0] b [0:13];
    int n;
    b[0] = 8'hff;
    b[1] = 8'hfe;
    b[2] = 8'hfd;
    b[3] = 8'hfc;
    b[4] = id;
    for (int i = 0; i < 8; i++)
      b[5+i] = es[63-8*i -: 8];
    b[13] = 8'hfb;
    lat = 0;
    while (tx_valid !== 1'b1 && lat < 40) begin
      @(posedge mclk);
      lat++;
    end
    snap = {io_mode, baud_sel};
    n = 0;
    while (gcfi_host_i.rxq.size() < 14 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (!ok)
      check(gcfi_host_i.rxq.size(), 0);
    else begin
      check(gcfi_host_i.rxq.size(), 14);
      for (int i = 0; i < 14; i++)
        check(gcfi_host_i.rxq[i], b[i]);
    end
    gcfi_host_i.rxq.delete();
  endtask
  task cmd(input logic [7:0] id, input logic [7:0] fn, input logic [7:0] sub,
           input logic [7:0] rw, input logic [31:0] d, input logic [31:0] ed,
           input logic ok = 1'b1, input logic [7:0] h0 = 8'hff,
           input logic [7:0] e = 8'hfb);
    gcfi_host_i.send(id, seg(fn, sub, rw, d), h0, e);
    expect_frame(id, seg(fn, sub, rw, ed), ok);
  endtask
  task t_reset;
    check(target_pos, 8'h00);
    check({force_open, force_close}, 16'h6464);
    check(baud_sel, 8'h00);
    av(1'b0, `GCFI_A_CTRL, 32'h0);
    check(q, 32'h00000001);
    av(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
  endtask
  task t_force;
    slow <= 1'b1;
    cmd(8'h01, 8'h05, 8'h02, 8'h01, 32'h1e, 32'h1e);
    check(force_close, 8'h1e);
    cmd(8'h01, 8'h05, 8'h03, 8'h01, 32'h50, 32'h50);
    check(force_open, 8'h50);
    cmd(8'h01, 8'h05, 8'h02, 8'h01, 32'hffffffff, 32'hffffffff);
    cmd(8'h01, 8'h05, 8'h02, 8'h01, 32'h13, 32'h13);
    check(force_close, 8'h1e);
    cmd(8'h01, 8'h05, 8'h03, 8'h00, 32'h12345678, 32'h50);
    av(1'b0, `GCFI_A_SETPT, 32'h0);
    check(q, 32'h00501e00);
    slow <= 1'b0;
  endtask
  task t_move;
    cmd(8'h01, 8'h06, 8'h02, 8'h01, 32'h3c, 32'h3c);
    check(target_pos, 8'h3c);
    cmd(8'h01, 8'h0f, 8'h01, 8'h00, 32'h0, 32'h0);
    cmd(8'h01, 8'h06, 8'h02, 8'h01, 32'h10, 32'h10);
    cmd(8'h01, 8'h06, 8'h02, 8'h01, 32'h65, 32'h65);
    check({target_pos, moves[7:0]}, 16'h1002);
    at_target_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    cmd(8'h01, 8'h0f, 8'h01, 8'h00, 32'h0, 32'h2);
    at_target_pin <= 1'b0;
    cmd(8'h01, 8'h06, 8'h02, 8'h01, 32'h20, 32'h20);
    caught_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    cmd(8'h01, 8'h0f, 8'h01, 8'h00, 32'h0, 32'h3);
    av(1'b0, `GCFI_A_STAT, 32'h0);
    check(q[1:0], 2'h3);
  endtask
  task t_init;
    cmd(8'h01, 8'h08, 8'h01, 8'h01, 32'h1, 32'h1);
    cmd(8'h01, 8'h08, 8'h01, 8'h00, 32'h0, 32'ha5);
    cmd(8'h01, 8'h08, 8'h02, 8'h01, 32'h0, 32'h0);
    cmd(8'h01, 8'h08, 8'h02, 8'h01, 32'h0, 32'h0);
    check(inits, 2);
    init_ack_pin <= 1'b1;
    expect_frame(8'h01, seg(8'h08, 8'h02, 8'h00, 32'h1), 1'b1);
    cmd(8'h01, 8'h08, 8'h02, 8'h00, 32'h0, 32'h1);
  endtask
  task t_config;
    int l0;
    cmd(8'h01, 8'h05, 8'h02, 8'h00, 32'h0, 32'h1e);
    l0 = lat;
    cmd(8'h01, 8'h14, 8'h01, 8'h01, 32'h3, 32'h3);
    check(snap[7:0], 8'h03);
    check(lat, l0 + 1);
    cmd(8'h01, 8'h14, 8'h01, 8'h00, 32'h0, 32'h3);
    cmd(8'h01, 8'h10, 8'h09, 8'h01, 32'h1, 32'h1);
    check(snap[8], 1'b1);
    cmd(8'h01, 8'h13, 8'h01, 8'h00, 32'h0, `GCFI_VERSION);
    cmd(8'h00, 8'h12, 8'h01, 8'h01, 32'h2, 32'h2);
    av(1'b0, `GCFI_A_CTRL, 32'h0);
    check(q[7:0], 8'h02);
    cmd(8'h01, 8'h06, 8'h02, 8'h00, 32'h0, 32'h0, 1'b0);
    cmd(8'h02, 8'h12, 8'h01, 8'h00, 32'h0, 32'h2);
    av(1'b1, `GCFI_A_CTRL, 32'h1);
    av(1'b0, `GCFI_A_CTRL, 32'h0);
    check(q, 32'h00000001);
  endtask
  task t_bad;
    int m0;
    m0 = moves;
    for (int k = 0; k < 4; k++)
      cmd(k == 3 ? 8'h05 : 8'h01, 8'h06, 8'h02, k == 2 ? 8'h02 : 8'h01,
          32'h30, 32'h30, 1'b0, k == 0 ? 8'hfe : 8'hff,
          k == 1 ? 8'hfa : 8'hfb);
    check({target_pos, moves[7:0]}, {8'h20, m0[7:0]});
  endtask
  task can_cmd(input logic [63:0] d, input logic [63:0] es);
    int n;
    @(posedge mclk);
    can_rx_id <= 11'h001;
    can_rx_data <= d;
    can_rx_valid <= 1'b1;
    @(posedge mclk);
    can_rx_valid <= 1'b0;
    n = 0;
    while (can_tx_valid !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check(can_tx_id, 11'h001);
    check(can_tx_data, es);
  endtask
  task t_can;
    can_cmd(seg(8'h06, 8'h02, 8'h00, 32'hdeadbeef),
            seg(8'h06, 8'h02, 8'h00, 32'h20));
    can_cmd(seg(8'h15, 8'h01, 8'h01, 32'h1),
            seg(8'h15, 8'h01, 8'h01, 32'h1));
    check(drop_en, 1'b1);
    av(1'b0, `GCFI_A_CFG, 32'h0);
    check(q, 32'h00000303);
  endtask
  initial begin
    {rx_valid, can_rx_valid, init_ack_pin, at_target_pin} = 4'h0;
    {caught_pin, avs_read, avs_write, slow, resetn} = 5'h00;
    {rx_byte, avs_address, can_rx_id} = 27'h0;
    {can_rx_data, avs_writedata} = 96'h0;
    {fails, compares, inits, moves} = 128'h0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    $display("reset test done");
    t_force();
    $display("force test done");
    t_move();
    $display("position test done");
    t_init();
    $display("initialization test done");
    t_config();
    $display("configuration test done");
    t_bad();
    $display("bad frame test done");
    t_can();
    $display("can test done");
    conclude();
  end
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule // test_gripper_command_frame_interpreter
`default_nettype wire
